// ---- core/qsr_pkg.sv ----
// constants and types shared by the quad-rate sram cycle logic
//////////////////////////////////////////////////////////////////////////////
package qsr_pkg;
	localparam int DATA_W = 18;
	localparam int LANES = 2;
	localparam int LANE_W = 9;
	localparam int ADDR_W = 19;
	localparam int MEM_AW = ADDR_W + 1;
	localparam int FIFO_DEPTH = 2;
	localparam int CNT_W = 2;
	localparam int CLK_PERIOD_PS = 8000;
	localparam int PS_PER_NS = 1000;
	localparam int DLL_LOCK_CYC = 1024;
	localparam int LOCK_W = 11;
	localparam int DLL_RESET_NS_DEF = 30;
	localparam int AVG_CYCLE_MAX_PS = 8400;
	localparam int STAT_W = 8;
	localparam logic BURST_OFS0 = 1'b0;
	localparam logic BURST_OFS1 = 1'b1;

	typedef enum logic {WR_IDLE, WR_WAIT1} qsr_wr_e;
	typedef enum logic [2:0] {RD_IDLE, RD_REQ0, RD_GET0, RD_REQ1, RD_GET1} qsr_rd_e;
endpackage : qsr_pkg

// ---- core/qsr_mem_if.sv ----
// array access signals between the cycle logic and the storage array
interface qsr_mem_if;
	import qsr_pkg::*;
	logic wr_en;
	logic [MEM_AW-1:0] wr_addr;
	logic [DATA_W-1:0] wr_data;
	logic [LANES-1:0] wr_lanes;
	logic rd_en;
	logic [MEM_AW-1:0] rd_addr;
	logic [DATA_W-1:0] rd_data;
	modport ctrl (output wr_en, wr_addr, wr_data, wr_lanes, rd_en, rd_addr, input rd_data);
	modport mem (input wr_en, wr_addr, wr_data, wr_lanes, rd_en, rd_addr, output rd_data);
endinterface : qsr_mem_if

// ---- core/qsr_mem.sv ----
// storage array with lane-masked write port and registered read port
module qsr_mem (
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic clk_en,
	qsr_mem_if.mem mif
);
	import qsr_pkg::*;

	logic [DATA_W-1:0] cells [0:(1 << MEM_AW)-1];
	logic [DATA_W-1:0] next_rd_data;

	// no reset on the cells: contents are undefined until written
	always_ff @(posedge sys_clk) begin
		if (clk_en && mif.wr_en) begin
			for (int i = 0; i < LANES; i++) begin
				if (mif.wr_lanes[i]) begin
					cells[mif.wr_addr][i*LANE_W +: LANE_W] <= mif.wr_data[i*LANE_W +: LANE_W];
				end
			end
		end
	end

	// a read in the same cycle as a write to that word returns the old word
	always_comb begin
		next_rd_data = mif.rd_data;
		if (mif.rd_en) begin
			next_rd_data = cells[mif.rd_addr];
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			mif.rd_data <= '0;
		end else if (clk_en) begin
			mif.rd_data <= next_rd_data;
		end
	end
endmodule : qsr_mem

// ---- core/qsr_top.sv ----
// quad-rate sram read and write cycle logic, sampled on the system clock
module qsr_top #(
	parameter int DLL_RESET_NS = qsr_pkg::DLL_RESET_NS_DEF
) (
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic clk_en,
	input wire logic in_clk_k,
	input wire logic in_clk_k_n,
	input wire logic out_clk_c,
	input wire logic out_clk_c_n,
	input wire logic [qsr_pkg::ADDR_W-1:0] addr,
	input wire logic rd_sel_n,
	input wire logic wr_sel_n,
	input wire logic [qsr_pkg::LANES-1:0] byte_write_sel_n,
	input wire logic [qsr_pkg::DATA_W-1:0] wr_data,
	output logic [qsr_pkg::DATA_W-1:0] rd_data,
	output logic rd_data_oe,
	output logic echo_clock_true,
	output logic echo_clock_comp,
	output logic dll_locked
);
	import qsr_pkg::*;

	// least time: round up to whole cycles
	localparam int RST_CYC_I = (DLL_RESET_NS * PS_PER_NS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam logic [STAT_W-1:0] RST_CYC = STAT_W'(RST_CYC_I);
	localparam logic [LOCK_W-1:0] LOCK_CYC = LOCK_W'(DLL_LOCK_CYC);
	localparam int PIN_W = 4 + ADDR_W + 2 + LANES + DATA_W;

	function automatic logic [DATA_W-1:0] lane_merge(input logic [DATA_W-1:0] old_w,
			input logic [DATA_W-1:0] new_w, input logic [LANES-1:0] sel);
		logic [DATA_W-1:0] w;
		w = old_w;
		for (int i = 0; i < LANES; i++) begin
			if (sel[i]) begin
				w[i*LANE_W +: LANE_W] = new_w[i*LANE_W +: LANE_W];
			end
		end
		return w;
	endfunction : lane_merge

	qsr_mem_if mif ();

	qsr_mem u_mem (
		.sys_clk(sys_clk),
		.arst_n(arst_n),
		.clk_en(clk_en),
		.mif(mif)
	);

	//////////////////////////////////////////////////////////////////////////
	// pin synchroniser: every pin, clocks included, passes two flops
	logic [PIN_W-1:0] pin_s1;
	logic [PIN_W-1:0] pin_s2;
	logic [3:0] clk_prev;
	logic k_s, kn_s, c_s, cn_s, rd_n_s, wr_n_s;
	logic [ADDR_W-1:0] a_s;
	logic [LANES-1:0] bw_s;
	logic [DATA_W-1:0] d_s;

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			pin_s1 <= '0;
			pin_s2 <= '0;
			clk_prev <= '0;
		end else if (clk_en) begin
			pin_s1 <= {in_clk_k, in_clk_k_n, out_clk_c, out_clk_c_n, addr, rd_sel_n, wr_sel_n,
				byte_write_sel_n, wr_data};
			pin_s2 <= pin_s1;
			clk_prev <= pin_s2[PIN_W-1 -: 4];
		end
	end

	assign {k_s, kn_s, c_s, cn_s, a_s, rd_n_s, wr_n_s, bw_s, d_s} = pin_s2;

	logic k_rise, kn_rise, c_rise, cn_rise, c_tied, l_rise, ln_rise, out_edge;
	assign k_rise = k_s & ~clk_prev[3];
	assign kn_rise = kn_s & ~clk_prev[2];
	assign c_rise = c_s & ~clk_prev[1];
	assign cn_rise = cn_s & ~clk_prev[0];
	// a running output pair is never high on both halves at once
	assign c_tied = c_s & cn_s;
	assign l_rise = c_tied ? k_rise : c_rise;
	assign ln_rise = c_tied ? kn_rise : cn_rise;
	assign out_edge = l_rise | ln_rise;

	//////////////////////////////////////////////////////////////////////////
	// lock interval and stopped-clock detection; no lower bound on the period
	logic [LOCK_W-1:0] lock_cnt, next_lock_cnt;
	logic [STAT_W-1:0] stat_cnt, next_stat_cnt;
	logic next_dll_locked;

	always_comb begin
		next_lock_cnt = lock_cnt;
		next_stat_cnt = stat_cnt;
		next_dll_locked = dll_locked;
		if (k_s != clk_prev[3]) begin
			next_stat_cnt = '0;
		end else if (stat_cnt < RST_CYC) begin
			next_stat_cnt = stat_cnt + STAT_W'(1);
		end
		if (stat_cnt >= RST_CYC) begin
			next_lock_cnt = '0;
			next_dll_locked = 1'b0;
		end else if (k_rise && !dll_locked) begin
			next_lock_cnt = lock_cnt + LOCK_W'(1);
			next_dll_locked = (next_lock_cnt == LOCK_CYC);
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			lock_cnt <= '0;
			stat_cnt <= '0;
			dll_locked <= 1'b0;
		end else if (clk_en) begin
			lock_cnt <= next_lock_cnt;
			stat_cnt <= next_stat_cnt;
			dll_locked <= next_dll_locked;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// write sequencing: first word on k, second on the following k_n
	qsr_wr_e wr_st, next_wr_st;
	logic [ADDR_W-1:0] wr_a, next_wr_a;
	logic [DATA_W-1:0] fwd_d [2];
	logic [DATA_W-1:0] next_fwd_d [2];
	logic [LANES-1:0] fwd_l [2];
	logic [LANES-1:0] next_fwd_l [2];
	logic [1:0] fwd_v, next_fwd_v;

	always_comb begin
		next_wr_st = wr_st;
		next_wr_a = wr_a;
		next_fwd_d = fwd_d;
		next_fwd_l = fwd_l;
		next_fwd_v = fwd_v;
		mif.wr_en = 1'b0;
		mif.wr_addr = {wr_a, BURST_OFS0};
		mif.wr_data = d_s;
		mif.wr_lanes = ~bw_s;
		case (wr_st)
			WR_IDLE: begin
				if (k_rise && !wr_n_s) begin
					mif.wr_en = 1'b1;
					mif.wr_addr = {a_s, BURST_OFS0};
					next_wr_a = a_s;
					next_fwd_d[0] = d_s;
					next_fwd_l[0] = ~bw_s;
					next_fwd_v = 2'b01;
					next_wr_st = WR_WAIT1;
				end
			end
			WR_WAIT1: begin
				if (kn_rise) begin
					mif.wr_en = 1'b1;
					mif.wr_addr = {wr_a, BURST_OFS1};
					next_fwd_d[1] = d_s;
					next_fwd_l[1] = ~bw_s;
					next_fwd_v = 2'b11;
					next_wr_st = WR_IDLE;
				end
			end
			default: next_wr_st = WR_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			wr_st <= WR_IDLE;
			wr_a <= '0;
			fwd_d <= '{default: '0};
			fwd_l <= '{default: '0};
			fwd_v <= '0;
		end else if (clk_en) begin
			wr_st <= next_wr_st;
			wr_a <= next_wr_a;
			fwd_d <= next_fwd_d;
			fwd_l <= next_fwd_l;
			fwd_v <= next_fwd_v;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// read sequencing; one command may wait while a burst is in flight
	qsr_rd_e rd_st, next_rd_st;
	logic [ADDR_W-1:0] ra, next_ra, rc_a, next_rc_a;
	logic rc_v, next_rc_v;
	logic push_v, push_rdy, fwd_hit;
	logic [DATA_W-1:0] push_d;
	logic ofs;

	assign ofs = (rd_st == RD_GET1) ? BURST_OFS1 : BURST_OFS0;
	assign fwd_hit = fwd_v[ofs] && (wr_a == ra);
	assign push_d = fwd_hit ? lane_merge(mif.rd_data, fwd_d[ofs], fwd_l[ofs]) : mif.rd_data;

	always_comb begin
		next_rd_st = rd_st;
		next_ra = ra;
		next_rc_a = rc_a;
		next_rc_v = rc_v;
		push_v = 1'b0;
		mif.rd_en = 1'b0;
		mif.rd_addr = {ra, BURST_OFS0};
		case (rd_st)
			RD_IDLE: begin
				// same-address write still missing its second word: wait for it
				if (rc_v && !(wr_st == WR_WAIT1 && wr_a == rc_a)) begin
					next_ra = rc_a;
					next_rc_v = 1'b0;
					next_rd_st = RD_REQ0;
				end
			end
			RD_REQ0: begin
				mif.rd_en = 1'b1;
				next_rd_st = RD_GET0;
			end
			RD_GET0: begin
				push_v = 1'b1;
				next_rd_st = push_rdy ? RD_REQ1 : RD_REQ0;
			end
			RD_REQ1: begin
				mif.rd_en = 1'b1;
				mif.rd_addr = {ra, BURST_OFS1};
				next_rd_st = RD_GET1;
			end
			RD_GET1: begin
				push_v = 1'b1;
				next_rd_st = push_rdy ? RD_IDLE : RD_REQ1;
			end
			default: next_rd_st = RD_IDLE;
		endcase
		// a new command wins over the take of the waiting one
		if (k_rise && !rd_n_s) begin
			next_rc_v = 1'b1;
			next_rc_a = a_s;
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			rd_st <= RD_IDLE;
			ra <= '0;
			rc_a <= '0;
			rc_v <= 1'b0;
		end else if (clk_en) begin
			rd_st <= next_rd_st;
			ra <= next_ra;
			rc_a <= next_rc_a;
			rc_v <= next_rc_v;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// two-entry word buffer; a full buffer holds the read sequencer back
	logic [DATA_W-1:0] fq [FIFO_DEPTH];
	logic [DATA_W-1:0] next_fq [FIFO_DEPTH];
	logic [CNT_W-1:0] fcnt, next_fcnt;
	logic push, pop;

	assign push_rdy = (fcnt != CNT_W'(FIFO_DEPTH));
	assign push = push_v & push_rdy;
	assign pop = out_edge & (fcnt != '0);

	always_comb begin
		next_fq = fq;
		next_fcnt = fcnt;
		case ({push, pop})
			2'b10: begin
				next_fq[fcnt[0]] = push_d;
				next_fcnt = fcnt + CNT_W'(1);
			end
			2'b01: begin
				next_fq[0] = fq[1];
				next_fcnt = fcnt - CNT_W'(1);
			end
			2'b11: begin
				next_fq[0] = (fcnt == CNT_W'(1)) ? push_d : fq[1];
				next_fq[1] = push_d;
			end
			default: next_fcnt = fcnt;
		endcase
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			fq <= '{default: '0};
			fcnt <= '0;
		end else if (clk_en) begin
			fq <= next_fq;
			fcnt <= next_fcnt;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// output launch and echo clocks
	logic [DATA_W-1:0] next_rd_data;
	logic next_rd_data_oe, next_echo_true, next_echo_comp;

	always_comb begin
		next_rd_data = rd_data;
		next_rd_data_oe = rd_data_oe;
		next_echo_true = c_tied ? k_s : c_s;
		next_echo_comp = c_tied ? kn_s : cn_s;
		if (out_edge) begin
			next_rd_data_oe = (fcnt != '0);
			if (fcnt != '0) begin
				next_rd_data = fq[0];
			end
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			rd_data <= '0;
			rd_data_oe <= 1'b0;
			echo_clock_true <= 1'b0;
			echo_clock_comp <= 1'b0;
		end else if (clk_en) begin
			rd_data <= next_rd_data;
			rd_data_oe <= next_rd_data_oe;
			echo_clock_true <= next_echo_true;
			echo_clock_comp <= next_echo_comp;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!arst_n);

	sequence s_word0_done;
		clk_en && rd_st == RD_GET0 && push_rdy;
	endsequence

	a_dll_lock_count: assert property (dll_locked == (lock_cnt == LOCK_CYC))
		else $error("lock flag disagrees with lock count");
	a_dll_static_reset: assert property ((clk_en && stat_cnt >= RST_CYC) |=> !dll_locked
		&& lock_cnt == '0)
		else $error("stopped input clock did not drop lock");
	a_out_idle_float: assert property ((clk_en && out_edge && fcnt == '0) |=> !rd_data_oe)
		else $error("read pins still driven after idle");
	a_out_launch_word: assert property ((clk_en && out_edge && fcnt != '0) |=>
		rd_data_oe && rd_data == $past(fq[0]))
		else $error("launched word is not the buffer head");
	a_fwd_write_data: assert property ((push_v && fwd_hit && fwd_l[ofs] == '1) |->
		push_d == fwd_d[ofs])
		else $error("read missed the forwarded write word");
	a_burst_second_word: assert property (s_word0_done ##1 clk_en |->
		rd_st == RD_REQ1 && mif.rd_addr == {ra, BURST_OFS1})
		else $error("second burst word not fetched at offset one");
	a_write_first_edge: assert property ((clk_en && wr_st == WR_IDLE && k_rise
		&& !wr_n_s) |-> mif.wr_en && mif.wr_addr == {a_s, BURST_OFS0} ##1 wr_st == WR_WAIT1)
		else $error("first write word not taken on k rise");
	a_write_second_edge: assert property ((clk_en && wr_st == WR_WAIT1 && kn_rise) |->
		mif.wr_en && mif.wr_addr[0] == BURST_OFS1)
		else $error("second write word not taken on k_n rise");
	a_write_lane_mask: assert property (mif.wr_en |-> mif.wr_lanes == ~bw_s)
		else $error("write lanes do not follow byte selects");
	a_echo_ref_k: assert property ((clk_en && c_tied) |=> echo_clock_true == $past(k_s))
		else $error("echo clock not taken from input clock");
	a_rd_wr_concurrent: assert property ((clk_en && wr_st == WR_IDLE && k_rise && !wr_n_s
		&& (rd_st != RD_IDLE || !rd_n_s)) |-> mif.wr_en)
		else $error("write held back by a running read");
endmodule : qsr_top

// ---- sim/qsr_ctrl_model.sv ----
// memory controller model: input and output clock pairs, commands, write words, read capture
module qsr_ctrl_model (
	output logic in_clk_k,
	output logic in_clk_k_n,
	output logic out_clk_c,
	output logic out_clk_c_n,
	output logic [qsr_pkg::ADDR_W-1:0] addr,
	output logic rd_sel_n,
	output logic wr_sel_n,
	output logic [qsr_pkg::LANES-1:0] byte_write_sel_n,
	output logic [qsr_pkg::DATA_W-1:0] wr_data,
	input wire logic [qsr_pkg::DATA_W-1:0] rd_data,
	input wire logic rd_data_oe,
	input wire logic echo_clock_true,
	input wire logic echo_clock_comp
);
	timeunit 1ns;
	timeprecision 1ps;
	import qsr_pkg::*;
	// a quarter of the 125 ns link period, far slower than the fastest allowed cycle
	localparam realtime QTR = 31.25;
	logic tie_c = 1'b0;
	logic [DATA_W-1:0] got[$];
	initial begin
		in_clk_k = 1'b0;
		in_clk_k_n = 1'b1;
		addr = 19'h0_0000;
		rd_sel_n = 1'b1;
		wr_sel_n = 1'b1;
		byte_write_sel_n = 2'h3;
		wr_data = 18'h0_0000;
	end
	//////////////////////////////////////////////////////////////////////////////
	// output pair follows the input pair, or stands high when tied
	assign out_clk_c = tie_c | in_clk_k;
	assign out_clk_c_n = tie_c | in_clk_k_n;
	// a receiver takes each word on an echo rise; the short wait rides out same-edge updates
	always @(posedge echo_clock_true or posedge echo_clock_comp) begin
		#1;
		if (rd_data_oe === 1'b1) begin
			got.push_back(rd_data);
		end
	end
	//////////////////////////////////////////////////////////////////////////////
	// one full input clock period; lines not in use show the inverse of their last value
	task automatic k_cycle(input logic rd, input logic wr, input logic [ADDR_W-1:0] a,
		input logic [DATA_W-1:0] w0, input logic [DATA_W-1:0] w1,
		input logic [LANES-1:0] s0, input logic [LANES-1:0] s1);
		addr = (rd | wr) ? a : ~addr;
		rd_sel_n = ~rd;
		wr_sel_n = ~wr;
		wr_data = wr ? w0 : ~wr_data;
		byte_write_sel_n = wr ? s0 : ~byte_write_sel_n;
		#QTR in_clk_k = 1'b1;
		in_clk_k_n = 1'b0;
		#QTR wr_data = wr ? w1 : ~wr_data;
		byte_write_sel_n = wr ? s1 : ~byte_write_sel_n;
		#QTR in_clk_k = 1'b0;
		in_clk_k_n = 1'b1;
		#QTR;
	endtask : k_cycle
endmodule : qsr_ctrl_model

// ---- sim/qsr_top_test.sv ----
// self-checking bench for the quad-rate sram cycle logic
module qsr_top_test;
	timeunit 1ns;
	timeprecision 1ps;
	import qsr_pkg::*;
	localparam int LIMIT = 50000;
	logic sys_clk = 1'b0;
	logic arst_n = 1'b0;
	logic in_clk_k, in_clk_k_n, out_clk_c, out_clk_c_n, rd_sel_n, wr_sel_n;
	logic [ADDR_W-1:0] addr;
	logic [LANES-1:0] byte_write_sel_n;
	logic [DATA_W-1:0] wr_data, rd_data;
	logic rd_data_oe, echo_clock_true, echo_clock_comp, dll_locked;
	int fails = 0;
	int compares = 0;
	int cyc = 0;
	always #4 sys_clk = ~sys_clk;
	//////////////////////////////////////////////////////////////////////////////
	// stop-detect stretched so the 62.5 ns half periods of the bench link clock keep lock
	qsr_top #(.DLL_RESET_NS(100)) u_qsr_top (.sys_clk(sys_clk), .arst_n(arst_n),
		.clk_en(1'b1), .in_clk_k(in_clk_k), .in_clk_k_n(in_clk_k_n), .out_clk_c(out_clk_c),
		.out_clk_c_n(out_clk_c_n), .addr(addr), .rd_sel_n(rd_sel_n), .wr_sel_n(wr_sel_n),
		.byte_write_sel_n(byte_write_sel_n), .wr_data(wr_data), .rd_data(rd_data),
		.rd_data_oe(rd_data_oe), .echo_clock_true(echo_clock_true),
		.echo_clock_comp(echo_clock_comp), .dll_locked(dll_locked));
	qsr_ctrl_model u_qsr_ctrl_model (.in_clk_k(in_clk_k), .in_clk_k_n(in_clk_k_n),
		.out_clk_c(out_clk_c), .out_clk_c_n(out_clk_c_n), .addr(addr), .rd_sel_n(rd_sel_n),
		.wr_sel_n(wr_sel_n), .byte_write_sel_n(byte_write_sel_n), .wr_data(wr_data),
		.rd_data(rd_data), .rd_data_oe(rd_data_oe), .echo_clock_true(echo_clock_true),
		.echo_clock_comp(echo_clock_comp));
	//////////////////////////////////////////////////////////////////////////////
	task automatic summarize();
		$display("compares=%0d fails=%0d", compares, fails);
		if (fails == 0 && compares > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : summarize
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == LIMIT) begin
			fails++;
			summarize();
		end
	end
	task automatic chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
		compares++;
		if (seen !== exp) begin
			fails++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task automatic idle(input int n);
		repeat (n) u_qsr_ctrl_model.k_cycle(1'b0, 1'b0, 19'h0_0000, 18'h0_0000, 18'h0_0000,
			2'h3, 2'h3);
	endtask : idle
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] w0,
		input logic [DATA_W-1:0] w1, input logic [LANES-1:0] s0, input logic [LANES-1:0] s1);
		u_qsr_ctrl_model.k_cycle(1'b0, 1'b1, a, w0, w1, s0, s1);
	endtask : wr
	// waits out the burst, then judges the two captured words and the released bus
	task automatic rd_check(input logic [DATA_W-1:0] e0, input logic [DATA_W-1:0] e1);
		idle(3);
		chk(DATA_W'(u_qsr_ctrl_model.got.size()), 18'h0_0002);
		chk(u_qsr_ctrl_model.got[0], e0);
		chk(u_qsr_ctrl_model.got[1], e1);
		chk({17'h0_0000, rd_data_oe}, 18'h0_0000);
		u_qsr_ctrl_model.got.delete();
	endtask : rd_check
	task automatic rd_burst(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e0,
		input logic [DATA_W-1:0] e1);
		u_qsr_ctrl_model.k_cycle(1'b1, 1'b0, a, 18'h0_0000, 18'h0_0000, 2'h3, 2'h3);
		rd_check(e0, e1);
	endtask : rd_burst
	//////////////////////////////////////////////////////////////////////////////
	// the memory stays idle through the whole lock interval
	task automatic test_lock();
		idle(1020);
		chk({17'h0_0000, dll_locked}, 18'h0_0000);
		idle(8);
		chk({17'h0_0000, dll_locked}, 18'h0_0001);
		$display("done test_lock");
	endtask : test_lock
	task automatic test_rw();
		wr(19'h0_0123, 18'h1_2345, 18'h2_abcd, 2'h0, 2'h0);
		idle(1);
		rd_burst(19'h0_0123, 18'h1_2345, 18'h2_abcd);
		$display("done test_rw");
	endtask : test_rw
	// lane masks differ between the two words of one burst, then a fully masked write
	task automatic test_lanes();
		wr(19'h0_0123, 18'h0_5a5a, 18'h3_0f0f, 2'h2, 2'h1);
		wr(19'h0_0123, 18'h3_ffff, 18'h3_ffff, 2'h3, 2'h3);
		idle(1);
		rd_burst(19'h0_0123, {9'h091, 9'h05a}, {9'h187, 9'h1cd});
		$display("done test_lanes");
	endtask : test_lanes
	// read and write of one address in the same cycle, right behind an older write
	task automatic test_fwd();
		wr(19'h7_0001, 18'h0_1111, 18'h0_2222, 2'h0, 2'h0);
		u_qsr_ctrl_model.k_cycle(1'b1, 1'b1, 19'h7_0001, 18'h3_3333, 18'h0_4444, 2'h0, 2'h0);
		rd_check(18'h3_3333, 18'h0_4444);
		$display("done test_fwd");
	endtask : test_fwd
	task automatic test_tied();
		u_qsr_ctrl_model.tie_c = 1'b1;
		idle(1);
		rd_burst(19'h7_0001, 18'h3_3333, 18'h0_4444);
		u_qsr_ctrl_model.tie_c = 1'b0;
		$display("done test_tied");
	endtask : test_tied
	task automatic test_stop();
		#300;
		chk({17'h0_0000, dll_locked}, 18'h0_0000);
		idle(1028);
		chk({17'h0_0000, dll_locked}, 18'h0_0001);
		$display("done test_stop");
	endtask : test_stop
	//////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (2) @(posedge sys_clk);
		#1 arst_n = 1'b1;
		test_lock();
		test_rw();
		test_lanes();
		test_fwd();
		test_tied();
		test_stop();
		summarize();
	end
endmodule : qsr_top_test
